/* File: decoder_defines.vh */
// timing constants and command codes for the tone-gated command decoder
// assumes a 200 MHz system clock; all times counted in sys_clk cycles
`ifndef DECODER_DEFINES_VH
`define DECODER_DEFINES_VH

`define CLK_HZ 200000000
`define ENABLE_ARM_MS 5000
`define MONITOR_MS 4000
`define FSK_GATE_MS 1000
`define FSK_LOSS_MS 500
`define SYNC_MS 100
`define GAP_MS 100
`define CMD_SYNC_MS 1000
`define TLM_TONE_MS 15000
// ms to cycles, plain multiply with no rounding
`define MS_CYC(ms) (((ms) * (`CLK_HZ / 1000)))

`define WORD_BITS 12
`define LOAD_PROG1 12'h003
`define LOAD_PROG2 12'h005
`define OFF_PROG1 12'h006
`define OFF_PROG2 12'h009
`define TLM_ON_CMD 12'h00A
`define SC_ADDR_DEF 12'h011

`endif

/* File: word_buffer.v */
// two-entry buffer for decoded command words
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
module word_buffer #(
   parameter WIDTH = 12
) (
   input wire sys_clk, // clock
   input wire reset, // async reset
   input wire in_valid, // word offered
   output wire in_ready, // space free
   input wire [WIDTH-1:0] in_data, // word in
   output wire out_valid, // word held
   input wire out_ready, // receiver takes
   output wire [WIDTH-1:0] out_data // word out
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg wp_r;
   reg rp_r;
   reg [1:0] cnt_r;
   wire push = in_valid && (cnt_r != 2'h2);
   wire pop = out_ready && (cnt_r != 2'h0);
   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
         mem_r[0] <= {WIDTH{1'b0}};
         mem_r[1] <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data;
            wp_r <= ~wp_r;
         end
         if (pop)
            rp_r <= ~rp_r;
         if (push && !pop)
            cnt_r <= cnt_r + 2'h1;
         else if (pop && !push)
            cnt_r <= cnt_r - 2'h1;
      end
   end
endmodule // word_buffer

/* File: command_decoder.v */
// one channel of the tone-gated ground command decoder
// assumes tone and bit inputs already synchronous to sys_clk; a second
// identical instance gives the redundant channel
//
// Function
// - arm after enable tone five seconds
// - monitor window starts at enable drop
// - one second fsk powers digital section
// - after sync shift bits, compare address
// - address in window latches power on
// - one second sync, twelve bits, two ones
// - programmer load/off routed to programmers
// - other commands go to distribution unit
// - after load, bits go to programmers
// - echo bits to verification telemetry
// - telemetry on by 15s tone or command
// - two independent channels, idle unpowered
// - half second fsk loss powers off once latched
// - long one level is sync, clears register
// - 100 ms bit gap clears register
`timescale 1ns/1ps
`include "decoder_defines.vh"
module command_decoder #(
   parameter [11:0] SC_ADDR = `SC_ADDR_DEF, // arbitrary address value
   parameter [31:0] ARM_CYC = `MS_CYC(`ENABLE_ARM_MS),
   parameter [31:0] MON_CYC = `MS_CYC(`MONITOR_MS),
   parameter [31:0] FSK_CYC = `MS_CYC(`FSK_GATE_MS),
   parameter [31:0] LOSS_CYC = `MS_CYC(`FSK_LOSS_MS),
   parameter [31:0] SYNC_CYC = `MS_CYC(`SYNC_MS),
   parameter [31:0] GAP_CYC = `MS_CYC(`GAP_MS),
   parameter [31:0] CSYNC_CYC = `MS_CYC(`CMD_SYNC_MS),
   parameter [31:0] TLM_CYC = `MS_CYC(`TLM_TONE_MS)
) (
   input wire sys_clk, // timebase clock
   input wire reset, // async reset, high
   input wire enable_tone, // enable tone present
   input wire fsk_tone, // fsk tone present
   input wire bit_one, // demodulated one level
   input wire bit_zero, // demodulated zero level
   input wire cdu_ready, // distribution unit takes word
   output reg digital_power_r, // digital section power
   output reg cdu_power_r, // distribution unit power
   output reg cdu_valid_r, // word valid to distribution unit
   output reg [11:0] cdu_lines_r, // twelve decode lines
   output reg prog1_load_r, // pulse: load programmer 1
   output reg prog2_load_r, // pulse: load programmer 2
   output reg prog1_off_r, // pulse: programmer 1 off
   output reg prog2_off_r, // pulse: programmer 2 off
   output reg prog_data_valid_r, // pulse: loading data bit
   output reg prog_data_r, // loading data value
   output reg verify_tlm_r, // verification telemetry echo
   output reg telemetry_on_r // telemetry enable
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ARMED = 3'h1;
   localparam ST_MONITOR = 3'h2;
   localparam ST_ADDR = 3'h3;
   localparam ST_CMD = 3'h4;
   localparam ST_DATA = 3'h5;

   function [3:0] ones12;
      input [11:0] w;
      integer i;
      begin
         ones12 = 4'h0;
         for (i = 0; i < 12; i = i + 1)
            ones12 = ones12 + {3'h0, w[i]};
      end
   endfunction

   reg [2:0] state_r;
   reg [31:0] en_cnt_r;
   reg [31:0] mon_cnt_r;
   reg [31:0] fsk_cnt_r;
   reg [31:0] loss_cnt_r;
   reg [31:0] one_cnt_r;
   reg [31:0] gap_cnt_r;
   reg [11:0] shift_r;
   reg [3:0] nbits_r;
   reg synced_r;
   reg long_sync_r;
   reg latched_r;
   reg echo_on_r;
   reg one_d_r;
   reg zero_d_r;
   wire one_rise = bit_one && !one_d_r;
   wire zero_rise = bit_zero && !zero_d_r;
   wire bit_evt = one_rise || zero_rise;
   // a bit is sampled at its leading edge; a long one later turns it to sync
   wire is_sync = bit_one && (one_cnt_r == SYNC_CYC);
   wire gap_hit = (gap_cnt_r == GAP_CYC);
   wire [11:0] shifted = {shift_r[10:0], one_rise};
   // telemetry-on is taken at decode, so a full buffer cannot lose it
   wire tlm_cmd_hit = (state_r == ST_CMD) && (nbits_r == 4'hC) && long_sync_r
         && (shift_r == `TLM_ON_CMD);

   wire buf_in_ready;
   wire buf_out_valid;
   wire [11:0] buf_out_data;
   reg buf_push_r;
   reg [11:0] buf_word_r;

   word_buffer #(.WIDTH(12)) u_buf (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(buf_push_r),
      .in_ready(buf_in_ready),
      .in_data(buf_word_r),
      .out_valid(buf_out_valid),
      .out_ready(cdu_ready && cdu_valid_r),
      .out_data(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // tone timers and bit timing, all on the one timebase
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         en_cnt_r <= 32'h0;
         one_cnt_r <= 32'h0;
         gap_cnt_r <= 32'h0;
         loss_cnt_r <= 32'h0;
         one_d_r <= 1'b0;
         zero_d_r <= 1'b0;
         telemetry_on_r <= 1'b0;
      end else begin
         one_d_r <= bit_one;
         zero_d_r <= bit_zero;
         if (!enable_tone)
            en_cnt_r <= 32'h0;
         else if (en_cnt_r != TLM_CYC)
            en_cnt_r <= en_cnt_r + 32'h1;
         if (enable_tone && en_cnt_r == TLM_CYC - 32'h1)
            telemetry_on_r <= 1'b1;
         else if (tlm_cmd_hit)
            telemetry_on_r <= 1'b1;
         if (!bit_one)
            one_cnt_r <= 32'h0;
         else if (one_cnt_r != SYNC_CYC)
            one_cnt_r <= one_cnt_r + 32'h1;
         if (bit_one || bit_zero || !digital_power_r)
            gap_cnt_r <= 32'h0;
         else if (!gap_hit)
            gap_cnt_r <= gap_cnt_r + 32'h1;
         if (fsk_tone || !latched_r)
            loss_cnt_r <= 32'h0;
         else if (loss_cnt_r != LOSS_CYC)
            loss_cnt_r <= loss_cnt_r + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // entry sequence, address and command word sequencing
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_IDLE;
         mon_cnt_r <= 32'h0;
         fsk_cnt_r <= 32'h0;
         shift_r <= 12'h000;
         nbits_r <= 4'h0;
         synced_r <= 1'b0;
         long_sync_r <= 1'b0;
         latched_r <= 1'b0;
         echo_on_r <= 1'b0;
         digital_power_r <= 1'b0;
         cdu_power_r <= 1'b0;
         buf_push_r <= 1'b0;
         buf_word_r <= 12'h000;
         prog1_load_r <= 1'b0;
         prog2_load_r <= 1'b0;
         prog1_off_r <= 1'b0;
         prog2_off_r <= 1'b0;
         prog_data_valid_r <= 1'b0;
         prog_data_r <= 1'b0;
         verify_tlm_r <= 1'b0;
      end else begin
         buf_push_r <= 1'b0;
         prog1_load_r <= 1'b0;
         prog2_load_r <= 1'b0;
         prog1_off_r <= 1'b0;
         prog2_off_r <= 1'b0;
         prog_data_valid_r <= 1'b0;
         if (echo_on_r)
            verify_tlm_r <= bit_one;
         else
            verify_tlm_r <= 1'b0;
         // powered sequencing: sync and gap handling
         if (digital_power_r) begin
            if (is_sync) begin
               shift_r <= 12'h000;
               nbits_r <= 4'h0;
               synced_r <= 1'b1;
               echo_on_r <= 1'b1;
            end else if (gap_hit) begin
               shift_r <= 12'h000;
               nbits_r <= 4'h0;
            end else if (bit_evt && synced_r && nbits_r != 4'hC) begin
               shift_r <= shifted;
               nbits_r <= nbits_r + 4'h1;
            end
            // command sync must be a long one level of a full second
            if (bit_one && one_cnt_r == SYNC_CYC)
               long_sync_r <= long_sync_r;
         end
         case (state_r)
            ST_IDLE: begin
               if (en_cnt_r >= ARM_CYC)
                  state_r <= ST_ARMED;
            end
            ST_ARMED: begin
               if (!enable_tone) begin
                  state_r <= ST_MONITOR;
                  mon_cnt_r <= 32'h0;
                  fsk_cnt_r <= 32'h0;
               end
            end
            ST_MONITOR, ST_ADDR: begin
               mon_cnt_r <= mon_cnt_r + 32'h1;
               if (fsk_tone && fsk_cnt_r != FSK_CYC)
                  fsk_cnt_r <= fsk_cnt_r + 32'h1;
               else if (!fsk_tone && state_r == ST_MONITOR)
                  fsk_cnt_r <= 32'h0;
               if (state_r == ST_MONITOR && fsk_cnt_r == FSK_CYC) begin
                  digital_power_r <= 1'b1;
                  cdu_power_r <= 1'b1;
                  state_r <= ST_ADDR;
               end
               if (state_r == ST_ADDR && nbits_r == 4'hC
                     && shift_r == SC_ADDR) begin
                  latched_r <= 1'b1;
                  state_r <= ST_CMD;
                  synced_r <= 1'b0;
                  long_sync_r <= 1'b0;
                  nbits_r <= 4'h0;
                  // the fsk gate count would else pass as a command sync
                  fsk_cnt_r <= 32'h0;
               end else if (mon_cnt_r == MON_CYC - 32'h1) begin
                  state_r <= ST_IDLE;
                  digital_power_r <= 1'b0;
                  cdu_power_r <= 1'b0;
                  synced_r <= 1'b0;
                  echo_on_r <= 1'b0;
               end
            end
            ST_CMD: begin
               if (bit_one && one_cnt_r >= SYNC_CYC)
                  fsk_cnt_r <= fsk_cnt_r + 32'h1;
               else if (!bit_one)
                  fsk_cnt_r <= 32'h0;
               if (fsk_cnt_r + SYNC_CYC >= CSYNC_CYC)
                  long_sync_r <= 1'b1;
               if (nbits_r == 4'hC && long_sync_r) begin
                  nbits_r <= 4'h0;
                  long_sync_r <= 1'b0;
                  synced_r <= 1'b0;
                  if (ones12(shift_r) == 4'h2) begin
                     case (shift_r)
                        `LOAD_PROG1: begin
                           prog1_load_r <= 1'b1;
                           state_r <= ST_DATA;
                        end
                        `LOAD_PROG2: begin
                           prog2_load_r <= 1'b1;
                           state_r <= ST_DATA;
                        end
                        `OFF_PROG1: prog1_off_r <= 1'b1;
                        `OFF_PROG2: prog2_off_r <= 1'b1;
                        default: begin
                           buf_push_r <= buf_in_ready;
                           buf_word_r <= shift_r;
                        end
                     endcase
                  end
               end else if (nbits_r == 4'hC)
                  nbits_r <= 4'h0;
            end
            ST_DATA: begin
               if (bit_evt) begin
                  prog_data_valid_r <= 1'b1;
                  prog_data_r <= one_rise;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         // loss of fsk tone while latched drops power
         if (latched_r && loss_cnt_r == LOSS_CYC) begin
            state_r <= ST_IDLE;
            latched_r <= 1'b0;
            digital_power_r <= 1'b0;
            cdu_power_r <= 1'b0;
            synced_r <= 1'b0;
            echo_on_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // distribution unit port fed from the buffer
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cdu_valid_r <= 1'b0;
         cdu_lines_r <= 12'h000;
      end else if (!cdu_valid_r || cdu_ready) begin
         cdu_valid_r <= buf_out_valid && !(cdu_valid_r && cdu_ready);
         cdu_lines_r <= buf_out_data;
      end
   end
endmodule // command_decoder

/* File: decoder_sva.sv */
// concurrent checks on the command decoder's ports
// assumes one sys_clk domain and async active-high reset
`timescale 1ns/1ps
module decoder_sva #(
   parameter [31:0] LOSS_CYC = 15,
   parameter [31:0] TLM_CYC = 80
) (
   input wire sys_clk, // clock
   input wire reset, // reset
   input wire enable_tone, // enable tone
   input wire fsk_tone, // fsk tone
   input wire bit_one, // one level
   input wire bit_zero, // zero level
   input wire cdu_ready, // unit takes
   input wire digital_power_r, // digital power
   input wire cdu_power_r, // unit power
   input wire cdu_valid_r, // word valid
   input wire [11:0] cdu_lines_r, // word
   input wire prog1_load_r, // load 1
   input wire prog2_load_r, // load 2
   input wire prog1_off_r, // off 1
   input wire prog2_off_r, // off 2
   input wire prog_data_valid_r, // data pulse
   input wire prog_data_r, // data bit
   input wire verify_tlm_r, // echo
   input wire telemetry_on_r // telemetry
);
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
////////////////////////////////////////////////////////////////////////////
// run lengths of fsk loss and enable presence, saturating
reg [15:0] lo_cnt_r;
reg [15:0] en_cnt_r;
always @(posedge sys_clk or posedge reset) begin
   if (reset) begin
      lo_cnt_r <= 16'h0000;
      en_cnt_r <= 16'h0000;
   end else begin
      lo_cnt_r <= fsk_tone ? 16'h0000
         : lo_cnt_r + (&lo_cnt_r ? 16'h0000 : 16'h0001);
      en_cnt_r <= !enable_tone ? 16'h0000
         : en_cnt_r + (&en_cnt_r ? 16'h0000 : 16'h0001);
   end
end
////////////////////////////////////////////////////////////////////////////
power_pair_a: assert property ($rose(digital_power_r) |-> cdu_power_r)
   else $error("unit power missing at power on");
power_fsk_a: assert property ($rose(cdu_power_r) |-> $past(fsk_tone))
   else $error("power on without fsk tone");
fsk_loss_a: assert property (lo_cnt_r == LOSS_CYC + 2 |-> !digital_power_r)
   else $error("power kept after fsk loss");
word_hold_a: assert property (cdu_valid_r && !cdu_ready |=>
   cdu_valid_r && $stable(cdu_lines_r))
   else $error("word dropped before taken");
two_ones_a: assert property (cdu_valid_r |-> $countones(cdu_lines_r) == 2)
   else $error("word without two ones");
prog_route_a: assert property (cdu_valid_r |-> !(cdu_lines_r inside
   {12'h003, 12'h005, 12'h006, 12'h009}))
   else $error("programmer command sent to unit");
load_pulse_a: assert property (prog1_load_r |=> !prog1_load_r)
   else $error("load pulse too long");
echo_src_a: assert property ($rose(verify_tlm_r) |-> $past(bit_one))
   else $error("echo without one level");
tlm_sticky_a: assert property (telemetry_on_r |=> telemetry_on_r[*3])
   else $error("telemetry dropped");
tlm_tone_a: assert property (en_cnt_r == TLM_CYC + 2 |-> telemetry_on_r)
   else $error("telemetry not on after long tone");
cover property (cdu_valid_r && cdu_ready);
cover property ($fell(digital_power_r));
cover property (prog_data_valid_r);
endmodule // decoder_sva

bind command_decoder decoder_sva #(.LOSS_CYC(LOSS_CYC), .TLM_CYC(TLM_CYC))
   i_sva (.sys_clk(sys_clk), .reset(reset), .enable_tone(enable_tone),
   .fsk_tone(fsk_tone), .bit_one(bit_one), .bit_zero(bit_zero),
   .cdu_ready(cdu_ready), .digital_power_r(digital_power_r),
   .cdu_power_r(cdu_power_r), .cdu_valid_r(cdu_valid_r),
   .cdu_lines_r(cdu_lines_r), .prog1_load_r(prog1_load_r),
   .prog2_load_r(prog2_load_r), .prog1_off_r(prog1_off_r),
   .prog2_off_r(prog2_off_r), .prog_data_valid_r(prog_data_valid_r),
   .prog_data_r(prog_data_r), .verify_tlm_r(verify_tlm_r),
   .telemetry_on_r(telemetry_on_r));

/* File: ground_station.sv */
// ground command station as seen through receiver and tone detectors
// assumes levels change just after a sys_clk rising edge
`timescale 1ns/1ps
module ground_station #(
   parameter HOLD = 3,
   parameter GAP = 3
) (
   input wire sys_clk, // clock
   output reg enable_tone, // enable tone
   output reg fsk_tone, // fsk tone
   output reg bit_one, // one level
   output reg bit_zero // zero level
);
initial begin
   enable_tone = 1'b0;
   fsk_tone = 1'b0;
   bit_one = 1'b0;
   bit_zero = 1'b0;
end
task level(input integer n, input [1:0] v);
   begin
      {bit_one, bit_zero} <= v;
      repeat (n) @(posedge sys_clk);
   end
endtask
// idle between bits is centre frequency, both levels low
task send_bits(input [11:0] w, input integer n);
   integer i;
   begin
      for (i = n - 1; i >= 0; i = i - 1) begin
         level(HOLD, w[i] ? 2'b10 : 2'b01);
         level(GAP, 2'b00);
      end
   end
endtask
task entry(input integer en_cyc);
   begin
      enable_tone <= 1'b1;
      repeat (en_cyc) @(posedge sys_clk);
      enable_tone <= 1'b0;
      fsk_tone <= 1'b1;
   end
endtask
task send_frame(input integer sync, input [11:0] w);
   begin
      level(sync, 2'b10);
      level(GAP, 2'b00);
      send_bits(w, 12);
   end
endtask
task stop;
   begin
      fsk_tone <= 1'b0;
      {bit_one, bit_zero} <= 2'b00;
      @(posedge sys_clk);
   end
endtask
endmodule // ground_station

/* File: test_tone_gated_command_decoder.sv */
// self-checking bench for one decoder channel with shortened timings
// assumes ground_station drives tones and bits, bench drives cdu_ready
`timescale 1ns/1ps
`include "decoder_defines.vh"
module test_tone_gated_command_decoder;
reg sys_clk = 1'b0;
reg reset = 1'b1;
reg cdu_ready = 1'b0;
wire enable_tone, fsk_tone, bit_one, bit_zero;
wire digital_power_r, cdu_power_r, cdu_valid_r, prog_data_valid_r;
wire prog1_load_r, prog2_load_r, prog1_off_r, prog2_off_r;
wire prog_data_r, verify_tlm_r, telemetry_on_r;
wire [11:0] cdu_lines_r;
integer n_errors = 0;
integer cmp_count = 0;
integer cnt [0:5];
integer k;
reg vt_d = 1'b0;
reg [7:0] data_q;
// shortened timings, in sys_clk cycles
localparam [31:0] ARM = 32'h28, MON = 32'hC8, FSK = 32'h14, LOSS = 32'hF;
localparam [31:0] SYNC = 32'hA, GAP = 32'hC, CSYNC = 32'h1E, TLM = 32'h50;
reg [11:0] cw_q [$];
always #2.5 sys_clk = ~sys_clk;
ground_station i_gs (.sys_clk(sys_clk), .enable_tone(enable_tone),
   .fsk_tone(fsk_tone), .bit_one(bit_one), .bit_zero(bit_zero));
command_decoder #(.ARM_CYC(ARM), .MON_CYC(MON), .FSK_CYC(FSK),
   .LOSS_CYC(LOSS), .SYNC_CYC(SYNC), .GAP_CYC(GAP), .CSYNC_CYC(CSYNC),
   .TLM_CYC(TLM)) i_dut (.sys_clk(sys_clk), .reset(reset),
   .enable_tone(enable_tone), .fsk_tone(fsk_tone), .bit_one(bit_one),
   .bit_zero(bit_zero), .cdu_ready(cdu_ready),
   .digital_power_r(digital_power_r), .cdu_power_r(cdu_power_r),
   .cdu_valid_r(cdu_valid_r), .cdu_lines_r(cdu_lines_r),
   .prog1_load_r(prog1_load_r), .prog2_load_r(prog2_load_r),
   .prog1_off_r(prog1_off_r), .prog2_off_r(prog2_off_r),
   .prog_data_valid_r(prog_data_valid_r), .prog_data_r(prog_data_r),
   .verify_tlm_r(verify_tlm_r), .telemetry_on_r(telemetry_on_r));
////////////////////////////////////////////////////////////////////////////
always @(posedge sys_clk) begin
   if (reset) begin
      for (k = 0; k < 6; k++)
         cnt[k] = 0;
      cw_q.delete();
   end else begin
      cnt[0] += prog1_load_r;
      cnt[1] += prog2_load_r;
      cnt[2] += prog1_off_r;
      cnt[3] += prog2_off_r;
      cnt[4] += prog_data_valid_r;
      if (prog_data_valid_r === 1'b1) data_q = {data_q[6:0], prog_data_r};
      if (cdu_valid_r === 1'b1 && cdu_ready) cw_q.push_back(cdu_lines_r);
      if (verify_tlm_r === 1'b1 && vt_d !== 1'b1) cnt[5] += 1;
   end
   vt_d = verify_tlm_r;
end
task chk(input [31:0] seen, input [31:0] exp);
   begin
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   end
endtask
task tally_and_finish;
   begin
      if (n_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
endtask
task cyc(input integer n);
   repeat (n) @(posedge sys_clk);
endtask
task do_reset;
   begin
      reset <= 1'b1;
      cyc(8);
      reset <= 1'b0;
      cyc(1);
      chk({digital_power_r, cdu_power_r, cdu_valid_r, telemetry_on_r}, 0);
   end
endtask
task cmd(input [11:0] w);
   begin
      i_gs.send_frame(32, w);
      cyc(4);
   end
endtask
////////////////////////////////////////////////////////////////////////////
// enable shorter than the arming time must not arm
task t_short;
   begin
      i_gs.entry(30);
      cyc(230);
      chk(digital_power_r, 0);
      i_gs.stop;
   end
endtask
// foreign address: power comes on, then the window runs out
task t_expire;
   begin
      i_gs.entry(45);
      cyc(23);
      chk({digital_power_r, cdu_power_r}, 2'b11);
      i_gs.send_frame(12, 12'h021);
      cyc(110);
      chk({digital_power_r, cdu_power_r}, 0);
      // echo rises: the sync tail, then the address's two ones
      chk(cnt[5], 3);
      i_gs.stop;
   end
endtask
task open_session;
   begin
      i_gs.entry(ARM + 5);
      cyc(FSK + 3);
      i_gs.send_frame(SYNC + 2, `SC_ADDR_DEF);
      cyc(100);
      chk(digital_power_r, 1);
   end
endtask
task t_session;
   begin
      open_session;
      cmd(12'h0C0);
      cmd(12'h300);
      cmd(12'h840);
      cmd(12'h007);
      chk({cdu_valid_r, cdu_lines_r}, 13'h10C0);
      cdu_ready <= 1'b1;
      cyc(8);
      chk(cw_q.size() >= 2, 1);
      chk({cw_q[0], cw_q[1]}, 24'h0C0300);
      chk(cw_q[cw_q.size() - 1] !== 12'h007, 1);
      cmd(`OFF_PROG1);
      cmd(`OFF_PROG2);
      cmd(`TLM_ON_CMD);
      chk(cnt[2], 1);
      chk(cnt[3], 1);
      chk(cw_q.size(), 3);
      chk(cw_q[2], `TLM_ON_CMD);
      chk(telemetry_on_r, 1);
      // after a load every bit is loading data, so it comes last
      cmd(`LOAD_PROG2);
      chk(cnt[1], 1);
      i_gs.send_bits(12'h0A5, 8);
      cyc(4);
      chk(cnt[4], 8);
      chk(data_q, 8'hA5);
      i_gs.stop;
      cyc(20);
      chk({digital_power_r, cdu_power_r}, 0);
   end
endtask
task t_load1;
   begin
      open_session;
      cmd(`LOAD_PROG1);
      chk(cnt[0], 1);
      i_gs.send_bits(12'h05A, 8);
      cyc(4);
      chk(cnt[4], 16);
      chk(data_q, 8'h5A);
      i_gs.stop;
      cyc(20);
   end
endtask
task t_tlm_tone;
   begin
      i_gs.entry(TLM + 10);
      chk(telemetry_on_r, 1);
      cyc(1);
      i_gs.stop;
      cyc(220);
   end
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
   repeat (20000) @(posedge sys_clk);
   n_errors++;
   tally_and_finish;
end
initial begin
   do_reset;
   t_short;
   chk(telemetry_on_r, 0);
   t_expire;
   t_session;
   t_load1;
   do_reset;
   t_tlm_tone;
   tally_and_finish;
end
endmodule // test_tone_gated_command_decoder
